// *** synth_prog_cfg.svh ***
// Field positions, widths and timing counts of the synthesizer programming link
`ifndef SYNTH_PROG_CFG_SVH
`define SYNTH_PROG_CFG_SVH
`define SP_WORD_BITS 18
`define SP_DATA_BITS 17
`define SP_REF_BITS 14
`define SP_RATIO_LSB 0
`define SP_RATIO_MSB 9
`define SP_FLOAT_BIT 10
`define SP_POL_BIT 11
`define SP_RSVD_BIT 12
`define SP_TEST_BIT 13
`define SP_CTL_LSB 0
`define SP_CTL_MSB 1
`define SP_SWALLOW_LSB 2
`define SP_SWALLOW_MSB 6
`define SP_MAIN_LSB 7
`define SP_MAIN_MSB 16
`define SP_CLK_HALF_DIV 4
`define SP_REG_CMD 12'h000
`define SP_REG_REF 12'h004
`define SP_REG_MAIN 12'h008
`define SP_REG_STAT 12'h00C
`endif

// *** synth_prog_pkg.sv ***
// Types of the synthesizer programming link: host state for the host end, power mode for the device end
package synth_prog_pkg;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_LOAD = 3'b100
  } host_state_t;
  typedef enum logic [1:0] {
    POWER_NORMAL = 2'b00,
    POWER_SYNC_DOWN = 2'b01,
    POWER_COUNTER_CLEAR = 2'b10,
    POWER_ASYNC_DOWN = 2'b11
  } power_mode_t;
endpackage

// *** synth_prog_if.sv ***
// Three-wire serial link between host controller and synthesizer
interface synth_prog_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  modport host (output ser_clk, output ser_data, output load_strobe);
  modport device (input ser_clk, input ser_data, input load_strobe);
endinterface

// *** synth_prog_device.sv ***
// Serially loaded divider programming registers of the synthesizer
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "synth_prog_cfg.svh"
module synth_prog_device
  import synth_prog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  synth_prog_if.device link,
  input wire logic ref_div_pulse,
  input wire logic main_div_pulse,
  input wire logic pump_up_req,
  input wire logic pump_down_req,
  output logic [9:0] ref_divide_ratio,
  output logic [4:0] swallow_count,
  output logic [9:0] main_count,
  output logic [1:0] control_pair,
  output logic pump_float_bit,
  output logic detector_polarity_bit,
  output logic test_mode,
  output logic sleep_active,
  output logic counter_clear,
  output logic pump_up,
  output logic pump_down,
  output logic pump_output_pin,
  output logic pump_output_oe,
  output logic [13:0] ref_reg_out,
  output logic [16:0] main_reg_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [2:0] clk_sync_r;
  logic [2:0] data_sync_r;
  logic [2:0] le_sync_r;
  logic [`SP_WORD_BITS-1:0] shift_r;
  logic [`SP_REF_BITS-1:0] ref_r;
  logic [`SP_DATA_BITS-1:0] main_r;
  logic clk_rise;
  logic le_rise;
  power_mode_t mode;

  // Pins pass two flops; third stage for edge finding and as the shifted data bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_r <= 3'h0;
      data_sync_r <= 3'h0;
      le_sync_r <= 3'h0;
    end else if (clk_en) begin
      clk_sync_r <= {clk_sync_r[1:0], link.ser_clk};
      data_sync_r <= {data_sync_r[1:0], link.ser_data};
      le_sync_r <= {le_sync_r[1:0], link.load_strobe};
    end
  end

  // Rising edges of serial clock and strobe
  assign clk_rise = clk_sync_r[1] & ~clk_sync_r[2];
  assign le_rise = le_sync_r[1] & ~le_sync_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Data taken a cycle ahead of the seen edge; host sets it up early
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (clk_en && clk_rise) begin
      shift_r <= {shift_r[`SP_WORD_BITS-2:0], data_sync_r[2]};
    end
  end

  // Reference latch: addressed strobe only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_r <= '0;
    end else if (clk_en && le_rise && shift_r[0]) begin
      ref_r <= shift_r[`SP_REF_BITS:1];
    end
  end

  // Main latch: addressed strobe only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_r <= '0;
    end else if (clk_en && le_rise && !shift_r[0]) begin
      main_r <= shift_r[`SP_WORD_BITS-1:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control pair decode
  assign mode = power_mode_t'(main_r[`SP_CTL_MSB:`SP_CTL_LSB]);

  logic sleep_nxt;
  logic sleep_r;
  // Sync power-down waits until no pump pulse is in progress
  always_comb begin
    sleep_nxt = sleep_r;
    unique case (mode)
      POWER_NORMAL, POWER_COUNTER_CLEAR: sleep_nxt = 1'b0;
      POWER_SYNC_DOWN: if (!pump_up_req && !pump_down_req) sleep_nxt = 1'b1;
      POWER_ASYNC_DOWN: sleep_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_r <= 1'b0;
    end else if (clk_en) begin
      sleep_r <= sleep_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pump steering and float
  logic test_on;
  logic floating;
  logic up_steer;
  logic dn_steer;
  assign test_on = ref_r[`SP_TEST_BIT];
  assign floating = ref_r[`SP_FLOAT_BIT] | sleep_r;
  assign up_steer = ref_r[`SP_POL_BIT] ? pump_up_req : pump_down_req;
  assign dn_steer = ref_r[`SP_POL_BIT] ? pump_down_req : pump_up_req;

  // Reference-side fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_divide_ratio <= '0;
      pump_float_bit <= 1'b0;
      detector_polarity_bit <= 1'b0;
      test_mode <= 1'b0;
      ref_reg_out <= '0;
    end else if (clk_en) begin
      ref_divide_ratio <= ref_r[`SP_RATIO_MSB:`SP_RATIO_LSB];
      pump_float_bit <= ref_r[`SP_FLOAT_BIT];
      detector_polarity_bit <= ref_r[`SP_POL_BIT];
      test_mode <= test_on;
      ref_reg_out <= ref_r;
    end
  end

  // Main-side fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      swallow_count <= '0;
      main_count <= '0;
      control_pair <= '0;
      main_reg_out <= '0;
    end else if (clk_en) begin
      swallow_count <= main_r[`SP_SWALLOW_MSB:`SP_SWALLOW_LSB];
      main_count <= main_r[`SP_MAIN_MSB:`SP_MAIN_LSB];
      control_pair <= main_r[`SP_CTL_MSB:`SP_CTL_LSB];
      main_reg_out <= main_r;
    end
  end

  // Power status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_active <= 1'b0;
      counter_clear <= 1'b0;
    end else if (clk_en) begin
      sleep_active <= sleep_r;
      counter_clear <= main_r[`SP_CTL_MSB];
    end
  end

  // Pump pin: divider monitor in test mode when not asleep, off when floating, else steered pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_output_pin <= 1'b0;
      pump_output_oe <= 1'b0;
    end else if (clk_en) begin
      if (test_on && !sleep_r) begin
        pump_up <= 1'b0;
        pump_down <= 1'b0;
        pump_output_pin <= ref_r[`SP_POL_BIT] ? main_div_pulse : ref_div_pulse;
        pump_output_oe <= 1'b1;
      end else if (floating) begin
        pump_up <= 1'b0;
        pump_down <= 1'b0;
        pump_output_pin <= 1'b0;
        pump_output_oe <= 1'b0;
      end else begin
        pump_up <= up_steer;
        pump_down <= dn_steer;
        pump_output_pin <= up_steer;
        pump_output_oe <= up_steer | dn_steer;
      end
    end
  end
endmodule

// *** synth_prog_host.sv ***
// Host controller: APB registers driving the three-wire programming link
`include "synth_prog_cfg.svh"
module synth_prog_host
  import synth_prog_pkg::*;
#(
  parameter int HALF_DIV = `SP_CLK_HALF_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  synth_prog_if.host link
);
  ////////////////////////////////////////////////////////////////////////
  logic [13:0] ref_r;
  logic [16:0] main_r;
  logic [`SP_WORD_BITS-1:0] word_r;
  logic [4:0] bits_r;
  logic [7:0] div_r;
  logic busy_r;
  logic pend_r;
  host_state_t state_r;
  logic wr;
  logic hit;
  logic tick;
  logic [`SP_WORD_BITS-1:0] start_word;

  assign wr = psel & penable & pwrite & pready;
  assign hit = (paddr == `SP_REG_CMD) || (paddr == `SP_REG_REF) ||
               (paddr == `SP_REG_MAIN) || (paddr == `SP_REG_STAT);

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `SP_REG_REF: prdata <= {18'h0, ref_r};
          `SP_REG_MAIN: prdata <= {15'h0, main_r};
          `SP_REG_STAT: prdata <= {30'h0, pend_r, busy_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Reserved bit forced zero, test mode forces float bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_r <= 14'h0002;
      main_r <= 17'h00180;
    end else if (clk_en && wr) begin
      if (paddr == `SP_REG_REF) begin
        ref_r <= {pwdata[13], 1'b0, pwdata[11], pwdata[10] | pwdata[13],
                  (pwdata[9:0] < 10'h002) ? 10'h002 : pwdata[9:0]};
      end
      if (paddr == `SP_REG_MAIN) begin
        main_r[6:0] <= pwdata[6:0];
        // Main count clamped to at least 3 and at least swallow count
        if (pwdata[16:7] < 10'h003 || pwdata[16:7] < {5'h00, pwdata[6:2]})
          main_r[16:7] <= (pwdata[6:2] > 5'h03) ? {5'h00, pwdata[6:2]} : 10'h003;
        else
          main_r[16:7] <= pwdata[16:7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cmd bit0 sends reference word, bit1 sends main word
  logic go_ref;
  logic go_main;
  assign go_ref = wr && paddr == `SP_REG_CMD && pwdata[0];
  assign go_main = wr && paddr == `SP_REG_CMD && pwdata[1];
  assign tick = (div_r == 8'(HALF_DIV - 1));
  // Reference word first when both are asked for
  assign start_word = go_ref ? {3'h0, ref_r, 1'b1} : {main_r, 1'b0};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HS_IDLE;
      word_r <= '0;
      bits_r <= 5'h00;
      div_r <= 8'h00;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      link.ser_clk <= 1'b0;
      link.ser_data <= 1'b0;
      link.load_strobe <= 1'b0;
    end else if (clk_en) begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      unique case (state_r)
        HS_IDLE: begin
          link.load_strobe <= 1'b0;
          if (go_ref || go_main || pend_r) begin
            word_r <= start_word;
            link.ser_data <= start_word[`SP_WORD_BITS-1];
            pend_r <= go_ref & (go_main | pend_r);
            busy_r <= 1'b1;
            bits_r <= 5'h00;
            div_r <= 8'h00;
            state_r <= HS_SHIFT;
          end else begin
            busy_r <= 1'b0;
          end
        end
        HS_SHIFT: begin
          if (go_main) pend_r <= 1'b1;
          if (tick) begin
            if (!link.ser_clk) begin
              if (bits_r == 5'(`SP_WORD_BITS)) begin
                link.load_strobe <= 1'b1;
                state_r <= HS_LOAD;
              end else begin
                link.ser_clk <= 1'b1;
              end
            end else begin
              link.ser_clk <= 1'b0;
              // Next bit set up a whole low phase before the rise
              link.ser_data <= word_r[`SP_WORD_BITS-2];
              word_r <= {word_r[`SP_WORD_BITS-2:0], 1'b0};
              bits_r <= bits_r + 5'h01;
            end
          end
        end
        HS_LOAD: begin
          if (go_main) pend_r <= 1'b1;
          if (tick) begin
            link.load_strobe <= 1'b0;
            state_r <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// *** synth_prog_monitor.sv ***
// Checker on the three-wire programming link
module synth_prog_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_q;
  logic [4:0] bit_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Serial clock rises since the last load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      bit_cnt <= 5'h00;
    end else begin
      clk_q <= ser_clk;
      if (load_strobe) begin
        bit_cnt <= 5'h00;
      end else if (ser_clk && !clk_q) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  ////////////////////////////////////////
  sequence s_high;
    ser_clk [*4] ##1 !ser_clk;
  endsequence
  sequence s_strobe;
    load_strobe [*4] ##1 !load_strobe;
  endsequence
  a_clk_high_len: assert property ($rose(ser_clk) |-> s_high)
    else $error("clock high phase length");
  a_clk_low_len: assert property ($fell(ser_clk) |-> !ser_clk [*4])
    else $error("clock low phase short");
  a_data_stable: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
    else $error("data moved in high phase");
  a_strobe_no_clk: assert property (load_strobe |-> !ser_clk)
    else $error("clock during load");
  a_word_bits: assert property ($rose(load_strobe) |-> bit_cnt == 5'h12)
    else $error("load after wrong bit count");
  a_no_extra_bit: assert property ($rose(ser_clk) |-> bit_cnt < 5'h12)
    else $error("too many bits");
  a_strobe_len: assert property ($rose(load_strobe) |-> s_strobe)
    else $error("load pulse length");
  a_frame_ends: assert property
    ($rose(ser_clk) && bit_cnt == 5'h00 |-> ##[1:400] $rose(load_strobe))
    else $error("word not loaded");
endmodule

// *** synth_divider_program_regs_tb.sv ***
// Bench joining host and device ends of the programming link
`include "synth_prog_cfg.svh"
module synth_divider_program_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, m, rdat, prdata;
  logic [3:0] stim = 4'h0;
  logic pready, pslverr, rerr, pfb, dpb, tm, slp, clr;
  logic pup, pdn, ppin, poe, u, d, sl;
  logic [3:0] s, w;
  logic [9:0] rat, mct, mc;
  logic [4:0] swl;
  logic [1:0] ctl;
  logic [13:0] rreg, sh_ref, cur_ref = 14'h0;
  logic [16:0] mreg, sh_main, cur_main = 17'h0;
  logic [17:0] cap;
  logic [48:0] exp_q[$];
  logic [48:0] e, prev = 49'h0;
  int error_cnt = 0;
  int checks_done = 0;
  synth_prog_if link();
  synth_prog_host u_synth_prog_host (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  synth_prog_device u_synth_prog_device (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .link(link), .ref_div_pulse(stim[0]), .main_div_pulse(stim[1]), .pump_up_req(stim[2]),
    .pump_down_req(stim[3]), .ref_divide_ratio(rat), .swallow_count(swl), .main_count(mct),
    .control_pair(ctl), .pump_float_bit(pfb), .detector_polarity_bit(dpb), .test_mode(tm),
    .sleep_active(slp), .counter_clear(clr), .pump_up(pup), .pump_down(pdn),
    .pump_output_pin(ppin), .pump_output_oe(poe), .ref_reg_out(rreg), .main_reg_out(mreg));
  synth_prog_monitor u_synth_prog_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .ser_clk(link.ser_clk), .ser_data(link.ser_data), .load_strobe(link.load_strobe));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) stim <= 4'($urandom);
  // Bits taken at the rising edge, as the device takes them
  always @(posedge link.ser_clk) cap <= {cap[16:0], link.ser_data};
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("%0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Notes the expected frames, then starts the send and waits for idle
  task automatic send(input logic [1:0] k);
    int n;
    n = 0;
    if (k[0]) begin
      cur_ref = sh_ref;
      exp_q.push_back({3'b000, cur_ref, 1'b1, cur_ref, cur_main});
    end
    if (k[1]) begin
      cur_main = sh_main;
      exp_q.push_back({cur_main, 1'b0, cur_ref, cur_main});
    end
    apb(1'b1, `SP_REG_CMD, {30'h0, k});
    do begin
      apb(1'b0, `SP_REG_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 200);
    if (rdat[0] !== 1'b0) error_cnt++;
    repeat (24) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(78582));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `SP_REG_REF, 32'h0);
    check(rdat, 32'h2);
    apb(1'b0, `SP_REG_MAIN, 32'h0);
    check(rdat, 32'h180);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    check(32'(rerr), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(rdat, 32'h0);
    sh_ref = 14'h0002;
    sh_main = 17'h00180;
    send(2'h3);
    $display("test reset shadows done");
    for (int i = 0; i < 9; i++) begin
      r = $urandom;
      m = $urandom;
      m[1:0] = 2'(i);
      if (i < 2) r[9:0] = 10'(i);
      if (i == 2) m[16:7] = 10'h001;
      if (i == 3) m[16:2] = 15'h021F;
      if (i == 8) begin
        r[9:0] = 10'h3FF;
        m[16:7] = 10'h3FF;
      end
      mc = (m[16:7] < 10'h003) ? 10'h003 : m[16:7];
      if (mc < 10'(m[6:2])) mc = 10'(m[6:2]);
      sh_ref = {r[13], 1'b0, r[11], r[10] | r[13],
                (r[9:0] < 10'h2) ? 10'h2 : r[9:0]};
      sh_main = {mc, m[6:0]};
      apb(1'b1, `SP_REG_REF, r);
      apb(1'b1, `SP_REG_MAIN, m);
      send(2'(i % 3 + 1));
      $display("test %0d done", i);
    end
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
  // Compares each loaded word with the oldest note
  initial begin
    forever begin
      @(posedge link.load_strobe);
      check(32'(rreg), 32'(prev[30:17]));
      check(32'(mreg), 32'(prev[16:0]));
      repeat (8) @(posedge clk_sys);
      e = exp_q.pop_front();
      prev = e;
      check(32'(cap), 32'(e[48:31]));
      check(32'(rreg), 32'(e[30:17]));
      check(32'(mreg), 32'(e[16:0]));
      check(32'(rat), 32'(e[26:17]));
      check(32'({tm, dpb, pfb}), 32'({e[30], e[28:27]}));
      check(32'({mct, swl, ctl}), 32'(e[16:0]));
      check(32'(clr), 32'(e[1]));
      if (e[1:0] != 2'b01) check(32'(slp), 32'(e[0]));
      // Pump pin against random requests and divider pulses
      if (e[1:0] != 2'b01) begin
        sl = (e[1:0] == 2'b11);
        repeat (4) begin
          @(negedge clk_sys);
          s = stim;
          u = e[28] ? s[2] : s[3];
          d = e[28] ? s[3] : s[2];
          if (e[30] && !sl) w = {1'b1, e[28] ? s[1] : s[0], 2'b00};
          else if (e[27] || sl) w = 4'h0;
          else w = {u | d, u, u, d};
          @(negedge clk_sys);
          check(32'({poe, ppin, pup, pdn}), 32'(w));
        end
      end
    end
  end
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule
